//--- logic/opaddr_pkg.sv
// constants, types and helpers for operand address generation
package opaddr_pkg;

    // ------------------------------------------------------------
    // field positions and fixed values
    // ------------------------------------------------------------
    localparam int STATUS_CARRY_POS = 7;
    localparam int STATUS_BANK_HI_POS = 4;
    localparam int STATUS_BANK_LO_POS = 3;
    localparam int DIRECT_SFR_POS = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] RST_PIPE_RESET = 2'h0;

    // ------------------------------------------------------------
    // opcodes handled specially
    // ------------------------------------------------------------
    localparam logic [7:0] OP_BR_CARRY = 8'h40;
    localparam logic [7:0] OP_BR_NOCARRY = 8'h50;
    localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
    localparam logic [7:0] OP_CODE_MOVE_DATAPTR = 8'h93;
    localparam logic [7:0] OP_CODE_MOVE_PC = 8'h83;
    localparam logic [7:0] OP_AND_DIR_ACC = 8'h52;
    localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
    localparam logic [7:0] OP_OR_DIR_ACC = 8'h42;
    localparam logic [7:0] OP_OR_DIR_IMM = 8'h43;
    localparam logic [7:0] OP_XOR_DIR_ACC = 8'h62;
    localparam logic [7:0] OP_XOR_DIR_IMM = 8'h63;
    localparam logic [7:0] OP_MOV_C_BIT = 8'ha2;
    localparam logic [7:0] OP_AND_C_BIT = 8'h82;
    localparam logic [7:0] OP_OR_C_BIT = 8'h72;
    localparam logic [7:0] OP_CPL_BIT = 8'hb2;
    localparam logic [7:0] OP_CLR_BIT = 8'hc2;
    localparam logic [7:0] OP_SET_BIT = 8'hd2;
    localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
    localparam logic [7:0] OP_CLR_ACC = 8'he4;
    localparam logic [7:0] OP_CLR_C = 8'hc3;
    localparam logic [7:0] OP_SET_C = 8'hd3;
    localparam logic [7:0] OP_CPL_C = 8'hb3;
    localparam logic [7:0] OP_INC_DATAPTR = 8'ha3;
    localparam logic [7:0] OP_MUL_AB = 8'ha4;
    localparam logic [7:0] OP_DIV_AB = 8'h84;
    localparam logic [7:0] OP_RESERVED = 8'ha5;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {MODE_NONE = 3'h0, MODE_IMM = 3'h1, MODE_DIRECT = 3'h2,
        MODE_INDIRECT = 3'h3, MODE_REG = 3'h4, MODE_REL = 3'h5, MODE_INDEX_DATAPTR = 3'h6,
        MODE_INDEX_PC = 3'h7} amode_t;
    typedef enum logic [2:0] {SPC_NONE = 3'h0, SPC_IRAM = 3'h1, SPC_SFR = 3'h2,
        SPC_BIT = 3'h3, SPC_CODE = 3'h4} space_t;
    typedef enum logic [2:0] {IMP_NONE = 3'h0, IMP_ACC = 3'h1, IMP_AUX = 3'h2,
        IMP_DATAPTR = 3'h3, IMP_CARRY = 3'h4} impl_t;
    typedef enum logic [2:0] {ALU_LOAD = 3'h0, ALU_SRC = 3'h1, ALU_AND = 3'h2,
        ALU_OR = 3'h3, ALU_XOR = 3'h4} alu_t;
    typedef enum logic [1:0] {DST_NONE = 2'h0, DST_MEM = 2'h1, DST_ACC = 2'h2,
        DST_CARRY = 2'h3} dst_t;
    typedef enum logic [2:0] {SRC_B1 = 3'h0, SRC_B2 = 3'h1, SRC_ACC = 3'h2,
        SRC_CARRY = 3'h3, SRC_ONE = 3'h4, SRC_ZERO = 3'h5} src_t;
    typedef enum logic [1:0] {BR_NONE = 2'h0, BR_ALWAYS = 2'h1, BR_CARRY = 2'h2,
        BR_NOCARRY = 2'h3} br_t;
    typedef enum logic {ST_IDLE = 1'b0, ST_READ = 1'b1} fsm_t;

    // decoded instruction class
    typedef struct packed {
        amode_t mode;
        logic bit_op;
        impl_t impl;
        alu_t alu;
        dst_t dst;
        src_t src;
        logic rd;
        br_t br;
    } decode_t;

    // whole state of the top module except the reset release pipe
    typedef struct packed {
        fsm_t st;
        logic ready;
        logic done;
        amode_t mode;
        impl_t impl;
        space_t space;
        logic [15:0] addr;
        logic mem_rd;
        logic mem_wr;
        logic [7:0] wdata;
        logic [7:0] imm;
        logic acc_we;
        logic [7:0] acc_wdata;
        logic carry_we;
        logic carry_wdata;
        logic pc_load;
        logic [15:0] pc_target;
        alu_t alu;
        dst_t dst;
        logic [7:0] src;
    } state_t;

    localparam state_t STATE_RESET = '{st: ST_IDLE, ready: 1'b1, mode: MODE_NONE,
        impl: IMP_NONE, space: SPC_NONE, alu: ALU_LOAD, dst: DST_NONE, default: '0};

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    // signed byte offset added to a 16-bit base, wrapping
    function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
        rel_target = base + {{8{off[7]}}, off};
    endfunction

    // upper half of the direct range is the register space
    function automatic space_t direct_space(input logic [7:0] a);
        direct_space = a[DIRECT_SFR_POS] ? SPC_SFR : SPC_IRAM;
    endfunction

endpackage

//--- logic/opaddr_if.sv
// carrier between the decoder and the address calculator
`timescale 1ns/10ps
interface opaddr_if;
    import opaddr_pkg::*;
    amode_t mode;
    logic bit_op;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [1:0] bank;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] acc;
    logic [15:0] data_ptr;
    logic [15:0] pc_next;
    space_t space;
    logic [15:0] addr;
    logic [15:0] target;
    modport calc (input mode, bit_op, opcode, byte1, bank, ptr0, ptr1, acc, data_ptr, pc_next,
        output space, addr, target);
    modport user (output mode, bit_op, opcode, byte1, bank, ptr0, ptr1, acc, data_ptr, pc_next,
        input space, addr, target);
endinterface

//--- logic/operand_addr_calc.sv
// effective operand address and branch target for each addressing mode
`timescale 1ns/10ps
module operand_addr_calc
    import opaddr_pkg::*;
(
    // decoder side
    opaddr_if.calc a
);

    // ------------------------------------------------------------
    // address per mode
    // ------------------------------------------------------------
    always_comb
    begin
        a.target = rel_target(a.pc_next, a.byte1);
        a.space = SPC_NONE;
        a.addr = '0;
        unique case (a.mode)
            MODE_NONE, MODE_IMM, MODE_REL:
            begin
                a.space = SPC_NONE;
            end
            MODE_DIRECT:
            begin
                a.addr = {ZERO_BYTE, a.byte1};
                a.space = a.bit_op ? SPC_BIT : direct_space(a.byte1);
            end
            MODE_INDIRECT:
            begin
                a.addr = {ZERO_BYTE, a.opcode[0] ? a.ptr1 : a.ptr0};
                a.space = SPC_IRAM;
            end
            MODE_REG:
            begin
                a.addr = {ZERO_BYTE, 3'h0, a.bank, a.opcode[2:0]};
                a.space = SPC_IRAM;
            end
            MODE_INDEX_DATAPTR:
            begin
                a.addr = a.data_ptr + {ZERO_BYTE, a.acc};
                a.space = SPC_CODE;
            end
            MODE_INDEX_PC:
            begin
                a.addr = a.pc_next + {ZERO_BYTE, a.acc};
                a.space = SPC_CODE;
            end
        endcase
    end

endmodule

//--- logic/cpu_operand_addressing.sv
// operand addressing: decode, memory access sequencing and branch target
// What this block does
// - immediate operand comes from instruction bytes, no memory access.
// - direct mode uses operand byte as address of register, RAM or bit.
// - register space and bit space reached only by direct addressing.
// - indirect mode uses working register 0 or 1 content as RAM address.
// - register mode picks one of eight working registers by opcode low bits.
// - accumulator, aux register, data pointer and carry implied by opcode.
// - two bank-select bits of status word choose the register bank.
// - relative target is program counter base plus second-byte offset.
// - relative offset is signed byte, minus 128 to plus 127.
// - branch on carry: carry clear no redirect, carry set load target.
// - indexed address is offset plus base from program counter or pointer.
// - code byte move reads code at accumulator plus pointer or program counter into accumulator.
// - bit operations use carry as accumulator, bit address from operand.
// - bit and byte addresses share encoding; opcode alone picks meaning.
// - logical op to direct location reads, combines, writes same location.
`timescale 1ns/10ps
module cpu_operand_addressing
    import opaddr_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // instruction stream
    input wire logic INSN_VALID,
    input wire logic [7:0] INSN_OPCODE,
    input wire logic [7:0] INSN_BYTE1,
    input wire logic [7:0] INSN_BYTE2,
    input wire logic [15:0] PC_NEXT,
    output logic READY,
    output logic DONE,
    // core state
    input wire logic [7:0] ACCUMULATOR_REGISTER,
    input wire logic [7:0] PROGRAM_STATUS_WORD,
    input wire logic [15:0] DATA_POINTER,
    input wire logic [7:0] REG_PTR0,
    input wire logic [7:0] REG_PTR1,
    // decode results
    output amode_t MODE,
    output impl_t IMPL,
    output logic [7:0] IMM,
    // memory access
    output logic MEM_RD,
    output logic MEM_WR,
    output space_t MEM_SPACE,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    // core write-back
    output logic ACC_WE,
    output logic [7:0] ACC_WDATA,
    output logic CARRY_WE,
    output logic CARRY_WDATA,
    output logic PC_LOAD,
    output logic [15:0] PC_TARGET
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_q;
    logic rst_n;

    // two-stage release of the asynchronous reset
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rst_pipe_q <= RST_PIPE_RESET;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
    assign rst_n = rst_pipe_q[1];

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    function automatic decode_t decode(input logic [7:0] op);
        decode_t r;
        r = '{mode: MODE_NONE, impl: IMP_NONE, alu: ALU_LOAD, dst: DST_NONE,
            src: SRC_B1, br: BR_NONE, default: '0};
        // generic rows by low nibble
        if (op[3])
            r.mode = MODE_REG;
        else if (op[3:1] == 3'h3)
            r.mode = MODE_INDIRECT;
        else if (op[3:0] == 4'h5 && op != OP_RESERVED)
            r.mode = MODE_DIRECT;
        else if (op[3:0] == 4'h4 && op[7:4] >= 4'h2 && op[7:4] <= 4'h7)
            r.mode = MODE_IMM;
        else if (op == 8'h94)
            r.mode = MODE_IMM;
        // special opcodes
        unique case (op)
            OP_BR_CARRY: r = '{mode: MODE_REL, impl: IMP_CARRY, alu: ALU_LOAD,
                dst: DST_NONE, src: SRC_B1, br: BR_CARRY, default: '0};
            OP_BR_NOCARRY: r = '{mode: MODE_REL, impl: IMP_CARRY, alu: ALU_LOAD,
                dst: DST_NONE, src: SRC_B1, br: BR_NOCARRY, default: '0};
            OP_SHORT_JUMP: r = '{mode: MODE_REL, impl: IMP_NONE, alu: ALU_LOAD,
                dst: DST_NONE, src: SRC_B1, br: BR_ALWAYS, default: '0};
            OP_CODE_MOVE_DATAPTR, OP_CODE_MOVE_PC: r = '{mode: op[4] ? MODE_INDEX_DATAPTR
                : MODE_INDEX_PC, impl: IMP_ACC, alu: ALU_LOAD, dst: DST_ACC, src: SRC_B1,
                br: BR_NONE, rd: 1'b1, default: '0};
            OP_AND_DIR_ACC, OP_OR_DIR_ACC, OP_XOR_DIR_ACC, OP_AND_DIR_IMM, OP_OR_DIR_IMM,
            OP_XOR_DIR_IMM: r = '{mode: MODE_DIRECT, impl: IMP_NONE,
                alu: op[5] ? ALU_XOR : (op[4] ? ALU_AND : ALU_OR), dst: DST_MEM,
                src: op[0] ? SRC_B2 : SRC_ACC, br: BR_NONE, rd: 1'b1, default: '0};
            OP_MOV_C_BIT, OP_AND_C_BIT, OP_OR_C_BIT: r = '{mode: MODE_DIRECT,
                impl: IMP_CARRY, alu: op[7] ? (op[5] ? ALU_LOAD : ALU_AND) : ALU_OR,
                dst: DST_CARRY, src: SRC_CARRY, br: BR_NONE, rd: 1'b1, bit_op: 1'b1,
                default: '0};
            OP_CPL_BIT: r = '{mode: MODE_DIRECT, impl: IMP_NONE, alu: ALU_XOR,
                dst: DST_MEM, src: SRC_ONE, br: BR_NONE, rd: 1'b1, bit_op: 1'b1,
                default: '0};
            OP_CLR_BIT, OP_SET_BIT, OP_MOV_BIT_C: r = '{mode: MODE_DIRECT,
                impl: op[6] ? IMP_NONE : IMP_CARRY, alu: ALU_SRC, dst: DST_MEM,
                src: op[6] ? (op[4] ? SRC_ONE : SRC_ZERO) : SRC_CARRY, br: BR_NONE,
                bit_op: 1'b1, default: '0};
            OP_CLR_ACC: r.impl = IMP_ACC;
            OP_CLR_C, OP_SET_C, OP_CPL_C: r.impl = IMP_CARRY;
            OP_INC_DATAPTR: r.impl = IMP_DATAPTR;
            OP_MUL_AB, OP_DIV_AB: r.impl = IMP_AUX;
            default: r.br = BR_NONE;
        endcase
        return r;
    endfunction

    // combine read data with the source operand
    function automatic logic [7:0] alu8(input alu_t f, input logic [7:0] data,
        input logic [7:0] src);
        unique case (f)
            ALU_LOAD: alu8 = data;
            ALU_SRC: alu8 = src;
            ALU_AND: alu8 = data & src;
            ALU_OR: alu8 = data | src;
            ALU_XOR: alu8 = data ^ src;
            default: alu8 = data;
        endcase
    endfunction

    // ------------------------------------------------------------
    // address calculation
    // ------------------------------------------------------------
    opaddr_if calc_bus();
    decode_t dec;
    logic accept;
    logic carry_in;
    logic take_branch;
    logic [7:0] src_val;

    assign dec = decode(INSN_OPCODE);
    assign carry_in = PROGRAM_STATUS_WORD[STATUS_CARRY_POS];
    assign calc_bus.mode = dec.mode;
    assign calc_bus.bit_op = dec.bit_op;
    assign calc_bus.opcode = INSN_OPCODE;
    assign calc_bus.byte1 = INSN_BYTE1;
    assign calc_bus.bank = PROGRAM_STATUS_WORD[STATUS_BANK_HI_POS:STATUS_BANK_LO_POS];
    assign calc_bus.ptr0 = REG_PTR0;
    assign calc_bus.ptr1 = REG_PTR1;
    assign calc_bus.acc = ACCUMULATOR_REGISTER;
    assign calc_bus.data_ptr = DATA_POINTER;
    assign calc_bus.pc_next = PC_NEXT;

    operand_addr_calc u_calc (
        .a(calc_bus.calc)
    );

    // branch decision and source operand
    always_comb
    begin
        unique case (dec.br)
            BR_NONE: take_branch = 1'b0;
            BR_ALWAYS: take_branch = 1'b1;
            BR_CARRY: take_branch = carry_in;
            BR_NOCARRY: take_branch = !carry_in;
        endcase
        unique case (dec.src)
            SRC_B1: src_val = INSN_BYTE1;
            SRC_B2: src_val = INSN_BYTE2;
            SRC_ACC: src_val = ACCUMULATOR_REGISTER;
            SRC_CARRY: src_val = {7'h00, carry_in};
            SRC_ONE: src_val = 8'h01;
            default: src_val = ZERO_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // state machine and output registers
    // ------------------------------------------------------------
    state_t q;
    state_t d;

    assign accept = INSN_VALID && q.ready;

    // next state
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        d.mem_rd = 1'b0;
        d.mem_wr = 1'b0;
        d.acc_we = 1'b0;
        d.carry_we = 1'b0;
        d.pc_load = 1'b0;
        unique case (q.st)
            ST_IDLE:
            begin
                if (accept)
                begin
                    d.mode = dec.mode;
                    d.impl = dec.impl;
                    d.space = calc_bus.space;
                    d.addr = calc_bus.addr;
                    d.imm = src_val;
                    d.pc_target = calc_bus.target;
                    d.pc_load = take_branch;
                    d.alu = dec.alu;
                    d.dst = dec.dst;
                    d.src = src_val;
                    if (dec.rd)
                    begin
                        d.mem_rd = 1'b1;
                        d.st = ST_READ;
                        d.ready = 1'b0;
                    end
                    else
                    begin
                        d.done = 1'b1;
                        d.mem_wr = (dec.dst == DST_MEM);
                        d.wdata = src_val;
                    end
                end
            end
            ST_READ:
            begin
                d.st = ST_IDLE;
                d.ready = 1'b1;
                d.done = 1'b1;
                d.wdata = alu8(q.alu, MEM_RDATA, q.src);
                d.mem_wr = (q.dst == DST_MEM);
                d.acc_we = (q.dst == DST_ACC);
                d.acc_wdata = MEM_RDATA;
                d.carry_we = (q.dst == DST_CARRY);
                d.carry_wdata = alu8(q.alu, {7'h00, MEM_RDATA[0]}, q.src) != ZERO_BYTE;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            q <= STATE_RESET;
        else
            q <= d;
    end

    // port map of the state
    assign READY = q.ready;
    assign DONE = q.done;
    assign MODE = q.mode;
    assign IMPL = q.impl;
    assign IMM = q.imm;
    assign MEM_RD = q.mem_rd;
    assign MEM_WR = q.mem_wr;
    assign MEM_SPACE = q.space;
    assign MEM_ADDR = q.addr;
    assign MEM_WDATA = q.wdata;
    assign ACC_WE = q.acc_we;
    assign ACC_WDATA = q.acc_wdata;
    assign CARRY_WE = q.carry_we;
    assign CARRY_WDATA = q.carry_wdata;
    assign PC_LOAD = q.pc_load;
    assign PC_TARGET = q.pc_target;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    logic [15:0] exp_target;
    logic [15:0] exp_code;
    logic [7:0] exp_ptr;
    logic [7:0] exp_reg;
    assign exp_target = rel_target(PC_NEXT, INSN_BYTE1);
    assign exp_code = DATA_POINTER + {ZERO_BYTE, ACCUMULATOR_REGISTER};
    assign exp_ptr = INSN_OPCODE[0] ? REG_PTR1 : REG_PTR0;
    assign exp_reg = {3'h0, PROGRAM_STATUS_WORD[STATUS_BANK_HI_POS:STATUS_BANK_LO_POS],
        INSN_OPCODE[2:0]};

    AST_IMM_NO_ACCESS: assert property (
        accept && dec.mode == MODE_IMM |=> !MEM_RD && !MEM_WR && IMM == $past(INSN_BYTE1))
        else $error("immediate operand wrong or memory touched");
    AST_DIRECT_ADDR: assert property (
        accept && dec.mode == MODE_DIRECT && !dec.bit_op |=> MEM_ADDR == {ZERO_BYTE,
        $past(INSN_BYTE1)} && (MEM_SPACE == SPC_SFR) == $past(INSN_BYTE1[DIRECT_SFR_POS]))
        else $error("direct address or space wrong");
    AST_SFR_DIRECT_ONLY: assert property (
        $rose(DONE) && (MEM_SPACE == SPC_SFR || MEM_SPACE == SPC_BIT) |-> MODE == MODE_DIRECT)
        else $error("register or bit space reached by a non-direct mode");
    AST_INDIRECT_PTR: assert property (
        accept && dec.mode == MODE_INDIRECT |=> MEM_SPACE == SPC_IRAM
        && MEM_ADDR == {ZERO_BYTE, $past(exp_ptr)})
        else $error("indirect address wrong");
    AST_REG_BANK: assert property (
        accept && dec.mode == MODE_REG |=> MEM_ADDR == {ZERO_BYTE, $past(exp_reg)})
        else $error("working register address wrong");
    AST_IMPLIED: assert property (
        accept && INSN_OPCODE == OP_CLR_ACC |=> IMPL == IMP_ACC && MODE == MODE_NONE && !MEM_RD)
        else $error("implied accumulator not reported");
    AST_BRANCH_TAKEN: assert property (
        accept && INSN_OPCODE == OP_BR_CARRY && carry_in |=> PC_LOAD
        && PC_TARGET == $past(exp_target) ##1 !PC_LOAD)
        else $error("taken branch target wrong");
    AST_BRANCH_HELD: assert property (
        accept && INSN_OPCODE == OP_BR_CARRY && !carry_in |=> !PC_LOAD)
        else $error("branch redirected with carry clear");
    AST_CODE_MOVE: assert property (
        accept && INSN_OPCODE == OP_CODE_MOVE_DATAPTR |=> MEM_RD && MEM_SPACE == SPC_CODE
        && MEM_ADDR == $past(exp_code) ##1 ACC_WE && ACC_WDATA == $past(MEM_RDATA))
        else $error("code byte move wrong");
    AST_BIT_READ: assert property (
        accept && INSN_OPCODE == OP_MOV_C_BIT |=> MEM_RD && MEM_SPACE == SPC_BIT
        && MEM_ADDR[7:0] == $past(INSN_BYTE1) ##1 CARRY_WE && CARRY_WDATA == $past(MEM_RDATA[0]))
        else $error("bit read into carry wrong");
    AST_RMW: assert property (
        accept && INSN_OPCODE == OP_AND_DIR_IMM |=> MEM_RD ##1 MEM_WR && $stable(MEM_ADDR)
        && MEM_WDATA == ($past(MEM_RDATA) & $past(INSN_BYTE2, 2)))
        else $error("read-modify-write wrong");

endmodule

//--- verification/mem_model.sv
// memory side partner: RAM, register, bit and code spaces
`timescale 1ns/10ps
module mem_model
    import opaddr_pkg::*;
(
    // access from the block
    input wire logic clk,
    input wire logic rd,
    input wire space_t space,
    input wire logic [15:0] addr,
    // read data
    output logic [7:0] rdata
);
    logic [7:0] last_q;
    logic [7:0] val;
    // contents are a fixed pattern of the address
    assign val = (space == SPC_BIT) ? {7'h00, addr[0] ^ addr[3]} : addr[7:0] ^ 8'h3c;
    // idle bus shows the inverse of the last value, never stale data
    assign rdata = rd ? val : ~last_q;
    // remember the last value handed out
    always_ff @(posedge clk)
    begin
        if (rd)
            last_q <= val;
    end
endmodule

//--- verification/cpu_operand_addressing_test.sv
// self-checking bench for operand address generation
`timescale 1ns/10ps
module cpu_operand_addressing_test;
    import opaddr_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, rdy, done, mrd, mwr, awe, cwe, cwd, pld;
    logic [7:0] opc = '0, b1 = '0, b2 = '0, acc = '0, status = '0, p0 = '0, p1 = '0;
    logic [7:0] imm, wd, awd, rdat, wr_d, acc_d;
    logic [15:0] pcn = '0, data_ptr = '0, madr, ptg, rd_ad;
    amode_t mode;
    impl_t impl;
    space_t sp;
    logic [2:0] rd_sp;
    logic s_rd, s_wr, s_pc, car_d;
    int fail_count = 0, tests_run = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    cpu_operand_addressing DUT (.CLK(clk), .RST_N(rst_n), .INSN_VALID(vld),
        .INSN_OPCODE(opc), .INSN_BYTE1(b1), .INSN_BYTE2(b2), .PC_NEXT(pcn), .READY(rdy),
        .DONE(done), .ACCUMULATOR_REGISTER(acc), .PROGRAM_STATUS_WORD(status),
        .DATA_POINTER(data_ptr), .REG_PTR0(p0), .REG_PTR1(p1), .MODE(mode), .IMPL(impl),
        .IMM(imm), .MEM_RD(mrd), .MEM_WR(mwr), .MEM_SPACE(sp), .MEM_ADDR(madr),
        .MEM_WDATA(wd), .MEM_RDATA(rdat), .ACC_WE(awe), .ACC_WDATA(awd), .CARRY_WE(cwe),
        .CARRY_WDATA(cwd), .PC_LOAD(pld), .PC_TARGET(ptg));
    mem_model mem (.clk(clk), .rd(mrd), .space(sp), .addr(madr), .rdata(rdat));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one instruction, strobes gathered until done
    task automatic issue(input logic [7:0] op, input logic [7:0] x1, input logic [7:0] x2);
        int n;
        n = 0;
        {s_rd, s_wr, s_pc} = '0;
        @(posedge clk);
        vld <= 1'b1;
        opc <= op;
        b1 <= x1;
        b2 <= x2;
        @(posedge clk);
        vld <= 1'b0;
        do
        begin
            #1;
            if (mrd === 1'b1) {s_rd, rd_sp, rd_ad} = {1'b1, sp, madr};
            if (mwr === 1'b1) {s_wr, wr_d} = {1'b1, wd};
            if (awe === 1'b1) acc_d = awd;
            if (cwe === 1'b1) car_d = cwd;
            if (pld === 1'b1) s_pc = 1'b1;
            n++;
            if (done !== 1'b1) @(posedge clk);
        end while (done !== 1'b1 && n < 4);
        chk(done, 1'b1);
    endtask

    task automatic t_imm();
        issue(8'h74, 8'h50, 8'h00);
        chk(mode, MODE_IMM);
        chk(imm, 8'h50);
        chk(s_rd, 1'b0);
    endtask

    task automatic t_branch();
        pcn <= 16'h1000;
        status <= 8'h80;
        issue(OP_BR_CARRY, 8'h80, 8'h00);
        chk(ptg, 16'h0f80);
        chk(s_pc, 1'b1);
        issue(OP_BR_CARRY, 8'h7f, 8'h00);
        chk(ptg, 16'h107f);
        chk(mode, MODE_REL);
        status <= 8'h00;
        issue(OP_BR_CARRY, 8'h10, 8'h00);
        chk(s_pc, 1'b0);
        issue(OP_BR_NOCARRY, 8'h02, 8'h00);
        chk({s_pc, ptg}, {1'b1, 16'h1002});
    endtask

    task automatic t_logic();
        acc <= 8'h81;
        issue(OP_AND_DIR_IMM, 8'h50, 8'hf5);
        chk(rd_ad, 16'h0050);
        chk(rd_sp, SPC_IRAM);
        chk(madr, 16'h0050);
        chk({s_wr, wr_d}, {1'b1, (8'h50 ^ 8'h3c) & 8'hf5});
        issue(OP_OR_DIR_ACC, 8'hd0, 8'h00);
        chk(rd_sp, SPC_SFR);
        chk(wr_d, (8'hd0 ^ 8'h3c) | 8'h81);
    endtask

    task automatic t_regs();
        p0 <= 8'h40;
        p1 <= 8'h90;
        issue(8'he7, 8'h00, 8'h00);
        chk({madr, 5'h00, sp}, {16'h0090, 8'(SPC_IRAM)});
        issue(8'he6, 8'h00, 8'h00);
        chk(madr, 16'h0040);
        status <= 8'h10;
        issue(8'h0d, 8'h00, 8'h00);
        chk(mode, MODE_REG);
        chk(madr, 16'h0015);
        status <= 8'h18;
        issue(8'h08, 8'h00, 8'h00);
        chk(madr, 16'h0018);
    endtask

    task automatic t_index_bit();
        acc <= 8'hf0;
        data_ptr <= 16'h1220;
        issue(OP_CODE_MOVE_DATAPTR, 8'h00, 8'h00);
        chk({rd_sp, rd_ad}, {SPC_CODE, 16'h1310});
        chk(acc_d, 8'h10 ^ 8'h3c);
        issue(OP_MOV_C_BIT, 8'h21, 8'h00);
        chk({rd_sp, rd_ad, 7'h00, car_d}, {SPC_BIT, 16'h0021, 8'h01});
        issue(OP_MOV_C_BIT, 8'h80, 8'h00);
        chk({rd_sp, 7'h00, car_d}, {SPC_BIT, 8'h00});
        issue(OP_CODE_MOVE_PC, 8'h00, 8'h00);
        chk({rd_sp, rd_ad}, {SPC_CODE, 16'h10f0});
        status <= 8'h80;
        issue(OP_OR_C_BIT, 8'h80, 8'h00);
        chk({rd_sp, 7'h00, car_d}, {SPC_BIT, 8'h01});
        issue(OP_SET_BIT, 8'h2b, 8'h00);
        chk({s_rd, s_wr, sp, madr, wd}, {2'b01, SPC_BIT, 16'h002b, 8'h01});
        issue(OP_CLR_ACC, 8'h00, 8'h00);
        chk(impl, IMP_ACC);
        issue(OP_INC_DATAPTR, 8'h00, 8'h00);
        chk(impl, IMP_DATAPTR);
        issue(OP_CLR_C, 8'h00, 8'h00);
        chk(impl, IMP_CARRY);
    endtask

    // valid held while a read is in flight must be ignored
    task automatic t_refuse();
        @(posedge clk);
        vld <= 1'b1;
        opc <= OP_AND_DIR_IMM;
        b1 <= 8'h50;
        b2 <= 8'hf5;
        @(posedge clk);
        opc <= OP_SET_BIT;
        #1;
        chk({rdy, mrd}, 2'b01);
        @(posedge clk);
        vld <= 1'b0;
        @(posedge clk);
        #1;
        chk({mwr, done, sp}, {2'b00, SPC_IRAM});
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reset, then every scenario in turn
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_imm();
        t_branch();
        t_logic();
        t_refuse();
        t_regs();
        t_index_bit();
        close_out();
    end

    // watchdog well beyond the expected run of under a hundred cycles
    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
